// [src/lrs_pkg.sv]
// Purpose: constants and types for the return/rotate/subtract execution datapath
// Assumes: 8-bit core, 7-bit file address, 25 MHz instruction clock
// Notes: opcodes are local encodings of the four instructions
package lrs_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W   = 15;
    localparam int NIB_W  = 4;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [PC_W-1:0]   PC_RESET  = 15'h0000;
    localparam logic              DEST_ACC  = 1'b0;
    localparam logic              DEST_FILE = 1'b1;
    localparam int MSB = DATA_W - 1;

    typedef enum logic [2:0]
    {
        LRS_OP_NONE = 3'h0,
        LRS_OP_RETI = 3'h1,
        LRS_OP_RLC  = 3'h2,
        LRS_OP_RRC  = 3'h3,
        LRS_OP_SUBI = 3'h4
    } lrs_op_t;

    // two-cycle return sequence
    typedef enum logic [0:0]
    {
        LRS_ST_IDLE = 1'b0,
        LRS_ST_RET2 = 1'b1
    } lrs_state_t;
endpackage

// [src/lrs_alu_if.sv]
`timescale 1ns/1ps
// Purpose: carrier between the sequencer and the arithmetic unit
// Assumes: purely combinational unit
// Notes: one modport per side
interface lrs_alu_if;
    import lrs_pkg::*;
    lrs_op_t           op;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] acc;
    logic              carry_in;
    logic [DATA_W-1:0] result;
    logic              carry_out;
    logic              half_out;
    logic              zero_out;
    modport seq (output op, output operand, output acc, output carry_in,
                 input result, input carry_out, input half_out, input zero_out);
    modport alu (input op, input operand, input acc, input carry_in,
                 output result, output carry_out, output half_out, output zero_out);
endinterface

// [src/lrs_alu.sv]
`timescale 1ns/1ps
// Purpose: combinational rotate and subtract unit
// Assumes: operands stable within the cycle
// Notes: for flags it does not own, carry passes carry_in through and half and zero are driven low
module lrs_alu
    import lrs_pkg::*;
(
    lrs_alu_if.alu bus
);
    logic [DATA_W:0]  diff;
    logic [NIB_W:0]   ndiff;

    always_comb
    begin
        diff      = {1'b0, bus.operand} - {1'b0, bus.acc};
        ndiff     = {1'b0, bus.operand[NIB_W-1:0]} - {1'b0, bus.acc[NIB_W-1:0]};
        bus.result    = bus.operand;
        bus.carry_out = bus.carry_in;
        bus.half_out  = 1'b0;
        bus.zero_out  = 1'b0;
        unique case (bus.op)
            LRS_OP_RLC:
            begin
                bus.result    = {bus.operand[MSB-1:0], bus.carry_in};
                bus.carry_out = bus.operand[MSB];
            end
            LRS_OP_RRC:
            begin
                bus.result    = {bus.carry_in, bus.operand[MSB:1]};
                bus.carry_out = bus.operand[0];
            end
            LRS_OP_SUBI:
            begin
                bus.result    = diff[DATA_W-1:0];
                // no borrow means acc <= literal
                bus.carry_out = ~diff[DATA_W];
                bus.half_out  = ~ndiff[NIB_W];
                bus.zero_out  = (diff[DATA_W-1:0] == '0);
            end
            default:
            begin
                bus.result = bus.operand;
            end
        endcase
    end
endmodule // lrs_alu

// [src/lrs_core.sv]
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Purpose: execution datapath for return-with-immediate, rotates and immediate-minus-accumulator
// Assumes: decode presents one instruction per cycle with i_valid; stack storage is outside
// Notes: o_ready low during the second return cycle; the sequencer must hold new instructions
module lrs_core
    import lrs_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    // decoded instruction
    input  wire logic              i_valid,
    input  wire lrs_op_t           i_op,
    input  wire logic [DATA_W-1:0] i_literal,
    input  wire logic [ADDR_W-1:0] i_file_addr,
    input  wire logic              i_dest,
    output logic                   o_ready,
    // file register ports
    output logic [ADDR_W-1:0]      o_file_raddr,
    input  wire logic [DATA_W-1:0] i_file_rdata,
    output logic                   o_file_we,
    output logic [ADDR_W-1:0]      o_file_waddr,
    output logic [DATA_W-1:0]      o_file_wdata,
    // return stack
    output logic                   o_stack_pop,
    input  wire logic [PC_W-1:0]   i_stack_top_entry,
    // architectural state
    output logic [DATA_W-1:0]      o_acc,
    output logic                   o_carry,
    output logic                   o_half_carry_flag,
    output logic                   o_zero,
    output logic                   o_pc_load,
    output logic [PC_W-1:0]        o_pc
);
    typedef struct packed
    {
        lrs_state_t        st;
        logic [DATA_W-1:0] acc;
        logic              carry;
        logic              half;
        logic              zero;
        logic              fwe;
        logic [ADDR_W-1:0] faddr;
        logic [DATA_W-1:0] fdata;
        logic              pop;
        logic              pcld;
        logic [PC_W-1:0]   pc;
    } lrs_core_t;

    lrs_core_t r;
    lrs_core_t next_r;
    lrs_alu_if alu_bus ();
    logic      take;

    lrs_alu u_alu
    (
        .bus (alu_bus.alu)
    );

    assign o_ready      = (r.st == LRS_ST_IDLE);
    assign take         = i_valid && o_ready;
    assign o_file_raddr = i_file_addr;

    always_comb
    begin
        alu_bus.op       = take ? i_op : LRS_OP_NONE;
        alu_bus.operand  = (i_op == LRS_OP_SUBI) ? i_literal : i_file_rdata;
        alu_bus.acc      = r.acc;
        alu_bus.carry_in = r.carry;
    end

    always_comb
    begin
        next_r      = r;
        next_r.fwe  = 1'b0;
        next_r.pop  = 1'b0;
        next_r.pcld = 1'b0;
        unique case (r.st)
            LRS_ST_IDLE:
            begin
                if (take)
                begin
                    unique case (i_op)
                        LRS_OP_RETI:
                        begin
                            // flags untouched; second cycle is the flushed fetch
                            next_r.acc  = i_literal;
                            next_r.pop  = 1'b1;
                            next_r.pcld = 1'b1;
                            next_r.pc   = i_stack_top_entry;
                            next_r.st   = LRS_ST_RET2;
                        end
                        LRS_OP_RLC, LRS_OP_RRC:
                        begin
                            next_r.carry = alu_bus.carry_out;
                            if (i_dest == DEST_FILE)
                            begin
                                next_r.fwe   = 1'b1;
                                next_r.faddr = i_file_addr;
                                next_r.fdata = alu_bus.result;
                            end
                            else
                            begin
                                next_r.acc = alu_bus.result;
                            end
                        end
                        LRS_OP_SUBI:
                        begin
                            next_r.acc   = alu_bus.result;
                            next_r.carry = alu_bus.carry_out;
                            next_r.half  = alu_bus.half_out;
                            next_r.zero  = alu_bus.zero_out;
                        end
                        default:
                        begin
                            next_r.st = LRS_ST_IDLE;
                        end
                    endcase
                end
            end
            LRS_ST_RET2:
            begin
                next_r.st = LRS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            r       <= '0;
            r.st    <= LRS_ST_IDLE;
            r.acc   <= ACC_RESET;
            r.pc    <= PC_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign o_acc             = r.acc;
    assign o_carry           = r.carry;
    assign o_half_carry_flag = r.half;
    assign o_zero            = r.zero;
    assign o_file_we         = r.fwe;
    assign o_file_waddr      = r.faddr;
    assign o_file_wdata      = r.fdata;
    assign o_stack_pop       = r.pop;
    assign o_pc_load         = r.pcld;
    assign o_pc              = r.pc;

    property p_ret_acc;
        @(posedge i_clk) disable iff (i_sys_rst)
        (take && i_op == LRS_OP_RETI) |=> (o_acc == $past(i_literal));
    endproperty
    a_ret_acc: assert property (p_ret_acc) else $error("return acc wrong");

    property p_ret_pc;
        @(posedge i_clk) disable iff (i_sys_rst)
        (take && i_op == LRS_OP_RETI)
            |=> (o_stack_pop && o_pc_load && o_pc == $past(i_stack_top_entry));
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("return pc wrong");

    property p_ret_two;
        @(posedge i_clk) disable iff (i_sys_rst)
        // flags compared across the accepting edge, where a slip would show
        (take && i_op == LRS_OP_RETI) |=> (!o_ready ##1 o_ready)
            and ($stable(o_carry) && $stable(o_zero) && $stable(o_half_carry_flag));
    endproperty
    a_ret_two: assert property (p_ret_two) else $error("return timing or flags");

    property p_rlc;
        @(posedge i_clk) disable iff (i_sys_rst)
        (take && i_op == LRS_OP_RLC && i_dest == DEST_FILE)
            |=> (o_file_wdata == {$past(i_file_rdata[MSB-1:0]), $past(o_carry)}
                 && o_carry == $past(i_file_rdata[MSB]));
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate left wrong");

    property p_rrc;
        @(posedge i_clk) disable iff (i_sys_rst)
        (take && i_op == LRS_OP_RRC && i_dest == DEST_ACC)
            |=> (o_acc == {$past(o_carry), $past(i_file_rdata[MSB:1])}
                 && o_carry == $past(i_file_rdata[0]));
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate right wrong");

    property p_dest;
        @(posedge i_clk) disable iff (i_sys_rst)
        (take && (i_op == LRS_OP_RLC || i_op == LRS_OP_RRC))
            |=> (o_file_we == ($past(i_dest) == DEST_FILE))
                && (!o_file_we || o_file_waddr == $past(i_file_addr))
                && (o_file_we || $stable(o_file_wdata));
    endproperty
    a_dest: assert property (p_dest) else $error("rotate destination wrong");

    property p_rot_flags;
        @(posedge i_clk) disable iff (i_sys_rst)
        (take && (i_op == LRS_OP_RLC || i_op == LRS_OP_RRC))
            |=> ($stable(o_zero) && $stable(o_half_carry_flag) && o_ready);
    endproperty
    a_rot_flags: assert property (p_rot_flags) else $error("rotate touched flags");

    property p_sub;
        @(posedge i_clk) disable iff (i_sys_rst)
        (take && i_op == LRS_OP_SUBI)
            |=> (o_acc == DATA_W'($past(i_literal) - $past(o_acc)))
                && (o_carry == ($past(o_acc) <= $past(i_literal)))
                && (o_half_carry_flag ==
                    ($past(o_acc[NIB_W-1:0]) <= $past(i_literal[NIB_W-1:0])))
                && (o_zero == (o_acc == '0)) && o_ready;
    endproperty
    a_sub: assert property (p_sub) else $error("subtract result or flags");

    c_ret:  cover property (@(posedge i_clk) take && i_op == LRS_OP_RETI);
    c_rot:  cover property (@(posedge i_clk) take && i_op == LRS_OP_RLC && i_dest);
    c_subz: cover property (@(posedge i_clk) take && i_op == LRS_OP_SUBI ##1 o_zero);
endmodule // lrs_core

// [tb/lrs_far_model.sv]
`timescale 1ns/1ps
// Purpose: far side of the datapath: file registers and return stack
// Assumes: file read is combinational; writes and pops land on the clock edge
// Notes: stack entries are synthetic return addresses, one per depth
module lrs_far_model
    import lrs_pkg::*;
(
    // clock
    input  wire logic              i_clk,
    // file register ports
    input  wire logic [ADDR_W-1:0] i_file_raddr,
    output logic [DATA_W-1:0]      o_file_rdata,
    input  wire logic              i_file_we,
    input  wire logic [ADDR_W-1:0] i_file_waddr,
    input  wire logic [DATA_W-1:0] i_file_wdata,
    // return stack
    input  wire logic              i_stack_pop,
    output logic [PC_W-1:0]        o_stack_top_entry
);
    logic [DATA_W-1:0] mem [128];
    logic [3:0]        depth = 4'h7;

    initial
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37 + 11);

    assign o_file_rdata      = mem[i_file_raddr];
    assign o_stack_top_entry = 15'h0100 + 15'(depth) * 15'h0111;

    always @(posedge i_clk)
    begin
        if (i_file_we === 1'b1)
            mem[i_file_waddr] <= i_file_wdata;
        if (i_stack_pop === 1'b1)
            depth <= depth - 4'h1;
    end
endmodule // lrs_far_model

// [tb/testbench.sv]
`timescale 1ns/1ps
// Purpose: self-checking bench for the return/rotate/subtract datapath
// Assumes: far-side model holds file registers and return stack
// Notes: expectations come from a shadow of acc, flags, file and stack
module testbench;
    import lrs_pkg::*;
    logic              i_clk = 1'b0, i_sys_rst = 1'b1, i_valid = 1'b0, i_dest = 1'b0;
    lrs_op_t           i_op = LRS_OP_NONE;
    logic [DATA_W-1:0] i_literal = 8'h00;
    logic [ADDR_W-1:0] i_file_addr = 7'h00;
    logic              o_ready, o_file_we, o_stack_pop, o_pc_load;
    logic              o_carry, o_half_carry_flag, o_zero;
    logic [ADDR_W-1:0] o_file_raddr, o_file_waddr;
    logic [DATA_W-1:0] i_file_rdata, o_file_wdata, o_acc;
    logic [PC_W-1:0]   i_stack_top_entry, o_pc, e_pc;
    int                error_cnt = 0;
    int                compares = 0;
    int                e_sp = 7;
    logic [DATA_W-1:0] e_acc = ACC_RESET;
    logic              e_c = 1'b0, e_hc = 1'b0, e_z = 1'b0;
    logic [DATA_W-1:0] e_mem [128];
    logic [15:0]       subs [5] = '{16'h0605, 16'h0f10, 16'h00ff, 16'hff00, 16'h0505};

    initial
        forever #20 i_clk = ~i_clk;

    lrs_core lrs_core_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid),
        .i_op(i_op), .i_literal(i_literal), .i_file_addr(i_file_addr), .i_dest(i_dest),
        .o_ready(o_ready), .o_file_raddr(o_file_raddr), .i_file_rdata(i_file_rdata),
        .o_file_we(o_file_we), .o_file_waddr(o_file_waddr), .o_file_wdata(o_file_wdata),
        .o_stack_pop(o_stack_pop), .i_stack_top_entry(i_stack_top_entry), .o_acc(o_acc),
        .o_carry(o_carry), .o_half_carry_flag(o_half_carry_flag), .o_zero(o_zero),
        .o_pc_load(o_pc_load), .o_pc(o_pc));

    lrs_far_model lrs_far_model_inst (.i_clk(i_clk), .i_file_raddr(o_file_raddr),
        .o_file_rdata(i_file_rdata), .i_file_we(o_file_we), .i_file_waddr(o_file_waddr),
        .i_file_wdata(o_file_wdata), .i_stack_pop(o_stack_pop),
        .o_stack_top_entry(i_stack_top_entry));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic run(input lrs_op_t op, input logic [7:0] k, input logic [6:0] a,
                       input logic d);
        logic [7:0] v, r;
        logic       nc, rot;
        int         n;
        n = 0;
        while (o_ready !== 1'b1 && n < 4)
        begin
            @(posedge i_clk);
            n++;
        end
        if (n == 4)
        begin
            error_cnt++;
            stop_test();
        end
        @(posedge i_clk);
        i_valid <= 1'b1;
        i_op <= op;
        i_literal <= k;
        i_file_addr <= a;
        i_dest <= d;
        v = e_mem[a];
        rot = (op == LRS_OP_RLC) || (op == LRS_OP_RRC);
        r = (op == LRS_OP_RLC) ? {v[6:0], e_c} : {e_c, v[7:1]};
        nc = (op == LRS_OP_RLC) ? v[7] : v[0];
        @(posedge i_clk);
        // hold a request into the stall cycle after a return: must be ignored
        i_valid <= (op == LRS_OP_RETI);
        i_op <= LRS_OP_SUBI;
        #1;
        case (op)
            LRS_OP_RETI:
            begin
                e_acc = k;
                e_pc = 15'h0100 + 15'(e_sp) * 15'h0111;
                e_sp--;
                chk("pc", o_pc, e_pc);
            end
            LRS_OP_RLC, LRS_OP_RRC:
            begin
                if (d == DEST_ACC)
                    e_acc = r;
                else
                    e_mem[a] = r;
                e_c = nc;
            end
            LRS_OP_SUBI:
            begin
                e_c = e_acc <= k;
                e_hc = e_acc[3:0] <= k[3:0];
                e_acc = k - e_acc;
                e_z = e_acc == 8'h00;
            end
            default: ;
        endcase
        chk("acc", o_acc, e_acc);
        chk("carry", o_carry, e_c);
        chk("half_carry", o_half_carry_flag, e_hc);
        chk("zero", o_zero, e_z);
        chk("pop_pc_load", {o_stack_pop, o_pc_load}, {2{op == LRS_OP_RETI}});
        chk("ready", o_ready, op != LRS_OP_RETI);
        chk("file_we", o_file_we, rot && d);
        chk("file_raddr", o_file_raddr, a);
        if (rot && d)
            chk("file_write", {o_file_waddr, o_file_wdata}, {a, r});
        if (op == LRS_OP_RETI)
        begin
            @(posedge i_clk);
            i_valid <= 1'b0;
            #1;
            chk("refused", {o_acc, o_carry, o_half_carry_flag, o_zero},
                {e_acc, e_c, e_hc, e_z});
            chk("ready_back", {o_ready, o_stack_pop, o_pc_load}, 3'h4);
        end
    endtask

    initial
    begin
        for (int i = 0; i < 128; i++)
            e_mem[i] = 8'(i * 37 + 11);
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        chk("reset", {o_acc, o_carry, o_half_carry_flag, o_zero, o_ready, o_file_we,
            o_stack_pop, o_pc_load, o_pc}, {ACC_RESET, 7'h08, PC_RESET});
        run(LRS_OP_RETI, 8'hff, 7'h00, 1'b0);
        run(LRS_OP_RETI, 8'h00, 7'h00, 1'b0);
        // each pair loads acc by return, then subtracts it from the literal
        foreach (subs[i])
        begin
            run(LRS_OP_RETI, subs[i][15:8], 7'h00, 1'b0);
            run(LRS_OP_SUBI, subs[i][7:0], 7'h00, 1'b0);
        end
        // both rotates, both destinations, lowest and highest file address
        for (int i = 0; i < 8; i++)
            run(i[0] ? LRS_OP_RRC : LRS_OP_RLC, 8'h00, i[2] ? 7'h7f : 7'h00, i[1]);
        run(LRS_OP_NONE, 8'h33, 7'h05, 1'b1);
        run(LRS_OP_RLC, 8'h00, 7'h00, 1'b1);
        stop_test();
    end
endmodule // testbench
